// ===== mode_ctrl.v
// Purpose: Operating-mode and function-control register bank with events.
// Assumes: Avalon-MM slave, byte addresses, single sys_clk domain.
// Notes:   Every access takes two cycles; waitrequest drops in the second.
//
// Function
// RL1 - A one in the soft-reset bit restores all defaults; the bit reads zero.
// RL2 - The battery-monitor enable runs the low-battery detector while set.
// RL3 - The wake-up timer enable keeps the timer running in every mode.
// RL4 - Expiry of the enabled wake-up timer raises the pin interrupt.
// RL5 - The slow-clock select picks RC at zero and 32 kHz crystal at one.
// RL6 - In FIFO mode the transmit-on bit clears itself once a packet is sent.
// RL7 - The host may abort transmission, first choosing unmodulated carrier.
// RL8 - With multi-packet receive off, a valid packet clears receive-on.
// RL9 - The tune bit keeps the synthesizer running in idle.
// RL10 - The ready bit holds the crystal oscillator running.
// RL11 - Control 2 holds a 3-bit antenna field over five single-bit controls.
// RL12 - Chip ready rises after crystal settling once requested, until idle.
// RL13 - Control bits read back as written; self-clearing bits read zero.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module mode_ctrl #(
  parameter [31:0] WUT_CYC = `WUT_PERIOD_CYC
)(
  input  wire        sys_clk,
  input  wire        srst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        batt_low_pin,
  input  wire        pkt_sent,
  input  wire        pkt_valid,
  input  wire        fifo_mode,
  output wire        lbd_enable,
  output wire        wut_enable,
  output wire        slow_clock_source_select,
  output wire        tx_enable,
  output wire        rx_enable,
  output wire        synth_idle_on,
  output wire        xtal_on,
  output wire [2:0]  antenna_div,
  output wire        multi_pkt_rx,
  output wire        auto_tx,
  output wire        low_duty_en,
  output wire        rx_fifo_clear,
  output wire        tx_fifo_clear,
  output wire        chip_ready,
  output reg         irq_r,
  output reg         gpio_irq_n_r
);

  localparam [31:0] SETTLE_CYC = `XTAL_SETTLE_CYC;

  reg  [7:0]            op1_r;
  reg  [7:0]            op2_r;
  reg  [`ST_WIDTH-1:0]  stat_r;
  reg  [`ST_WIDTH-1:0]  mask_r;
  reg                   ack_r;
  reg                   batt_meta_r;
  reg                   batt_sync_r;
  reg                   batt_prev_r;
  reg                   rdy_prev_r;
  wire                  req;
  wire                  wr_take;
  wire                  rd_load;
  wire [5:0]            wr_idx;
  wire                  wr_op1;
  wire                  wr_op2;
  wire                  wr_stat;
  wire                  wr_mask;
  wire                  settle_req;
  wire                  irq_any;
  wire                  soft_rst;
  wire                  wut_expire;
  wire                  rdy_level;
  wire                  lbd_event;
  wire [`ST_WIDTH-1:0]  events;
  wire [`ST_WIDTH-1:0]  stat_clr;
  wire [`ST_WIDTH-1:0]  stat_nxt;
  reg  [31:0]           rd_nxt;

  function [5:0] reg_index;
    input [7:0] addr;
    begin
      reg_index = addr[7:2];
    end
  endfunction

  // Every register write strobe is one decode of the taken write.
  function wr_hit;
    input       take;
    input [7:0] addr;
    input [5:0] index;
    begin
      wr_hit = take && (reg_index(addr) == index);
    end
  endfunction

  // The answer is always one cycle late, which keeps read data registered.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_take         = avs_write & ack_r & avs_byteenable[0];
  assign rd_load         = avs_read & ~ack_r;
  assign wr_idx          = reg_index(avs_address);
  assign wr_op1          = wr_hit(wr_take, avs_address, `OP1_INDEX);
  assign wr_op2          = wr_hit(wr_take, avs_address, `OP2_INDEX);
  assign wr_stat         = wr_hit(wr_take, avs_address, `INT_STAT_INDEX);
  assign wr_mask         = wr_hit(wr_take, avs_address, `INT_MASK_INDEX);

  // RL1 soft reset strobe.
  assign soft_rst = wr_op1 & avs_writedata[`OP1_SWRES];

  always @(posedge sys_clk)
  begin
    if (srst)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      op1_r <= `OP1_RESET;
      op2_r <= `OP2_RESET;
    end
    // RL1 restore all defaults.
    else if (soft_rst)
    begin
      op1_r <= `OP1_RESET;
      op2_r <= `OP2_RESET;
    end
    else
    begin
      // Software beats a self-clear that lands in the same cycle.
      if (wr_op1)
      begin
        // RL13 store written bits.
        op1_r <= {1'b0, avs_writedata[6:0]};
      end
      else
      begin
        // RL6 transmit self-clear.
        if (fifo_mode && pkt_sent)
          op1_r[`OP1_TX_ON] <= 1'b0;
        // RL8 receive self-clear.
        if (!op2_r[`OP2_MULTI_PKT] && pkt_valid)
          op1_r[`OP1_RX_ON] <= 1'b0;
      end
      // RL11 second register store.
      if (wr_op2)
        op2_r <= avs_writedata[7:0];
    end
  end

  // RL2 detector enable.
  assign lbd_enable = op1_r[`OP1_LBD_EN];
  // RL3 timer enable.
  assign wut_enable = op1_r[`OP1_WUT_EN];
  // RL5 slow clock select.
  assign slow_clock_source_select = op1_r[`OP1_SLOW_SEL];
  assign tx_enable = op1_r[`OP1_TX_ON];
  assign rx_enable = op1_r[`OP1_RX_ON];
  // RL9 synthesizer idle hold.
  assign synth_idle_on = op1_r[`OP1_SYNTH_ON];
  // RL10 crystal hold.
  assign xtal_on = op1_r[`OP1_XTAL_ON];
  // RL11 field outputs.
  assign antenna_div   = op2_r[`OP2_ANTDIV_HI:`OP2_ANTDIV_LO];
  assign multi_pkt_rx  = op2_r[`OP2_MULTI_PKT];
  assign auto_tx       = op2_r[`OP2_AUTO_TX];
  assign low_duty_en   = op2_r[`OP2_LOW_DUTY];
  assign rx_fifo_clear = op2_r[`OP2_RX_FIFO_CLR];
  assign tx_fifo_clear = op2_r[`OP2_TX_FIFO_CLR];

  // RL3 timer runs in any mode.
  wake_timer #(
    .PERIOD_CYC (WUT_CYC)
  ) u_wake_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .enable     (op1_r[`OP1_WUT_EN]),
    .expire_r   (wut_expire)
  );

  // Idle means crystal, transmitter and receiver are all off.
  assign settle_req = op1_r[`OP1_XTAL_ON] | op1_r[`OP1_TX_ON] |
                      op1_r[`OP1_RX_ON];

  // RL12 settle then ready.
  settle_timer #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_settle_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .request    (settle_req),
    .ready_r    (rdy_level)
  );

  assign chip_ready = rdy_level;

  // The comparator output is asynchronous, so it is synchronised first.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      batt_meta_r <= 1'b0;
      batt_sync_r <= 1'b0;
      batt_prev_r <= 1'b0;
      rdy_prev_r  <= 1'b0;
    end
    else
    begin
      batt_meta_r <= batt_low_pin;
      batt_sync_r <= batt_meta_r;
      batt_prev_r <= batt_sync_r & op1_r[`OP1_LBD_EN];
      rdy_prev_r  <= rdy_level;
    end
  end

  // RL2 gated threshold event.
  assign lbd_event = batt_sync_r & op1_r[`OP1_LBD_EN] & ~batt_prev_r;

  assign events[`ST_WUT] = wut_expire;
  assign events[`ST_LBD] = lbd_event;
  assign events[`ST_RDY] = rdy_level & ~rdy_prev_r;

  assign stat_clr = wr_stat ?
                    avs_writedata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  // A new event beats a clear landing in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < `ST_WIDTH; gi = gi + 1)
    begin : g_stat
      assign stat_nxt[gi] = events[gi] |
                            (stat_r[gi] & ~stat_clr[gi] & ~soft_rst);
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      stat_r <= {`ST_WIDTH{1'b0}};
      mask_r <= `INT_MASK_RESET;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (soft_rst)
        mask_r <= `INT_MASK_RESET;
      else if (wr_mask)
        mask_r <= avs_writedata[`ST_WIDTH-1:0];
    end
  end

  // Both pin polarities come from one term so they never disagree.
  assign irq_any = |(stat_r & mask_r);

  // RL4 interrupt on the pin.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_r        <= 1'b0;
      gpio_irq_n_r <= 1'b1;
    end
    else
    begin
      irq_r        <= irq_any;
      gpio_irq_n_r <= ~irq_any;
    end
  end

  // RL13 readback mux.
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (wr_idx)
      `OP1_INDEX:
        rd_nxt[7:0] = op1_r;
      `OP2_INDEX:
        rd_nxt[7:0] = op2_r;
      `INT_STAT_INDEX:
      begin
        rd_nxt[`ST_WIDTH-1:0] = stat_r;
        rd_nxt[`ST_RDY_LEVEL] = rdy_level;
      end
      `INT_MASK_INDEX:
        rd_nxt[`ST_WIDTH-1:0] = mask_r;
      default:
        rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (srst)
      avs_readdata <= 32'h00000000;
    else if (rd_load)
      avs_readdata <= rd_nxt;
  end

endmodule

// ===== mode_ctrl_defines.vh
// Purpose: Register map, field positions, reset values and timing counts.
// Assumes: A 50 MHz system clock.
// Notes:   Indices are word indices; byte address is four times the index.
`ifndef MODE_CTRL_DEFINES_VH
`define MODE_CTRL_DEFINES_VH

`define OP1_INDEX        6'h07
`define OP2_INDEX        6'h08
`define INT_STAT_INDEX   6'h10
`define INT_MASK_INDEX   6'h11

`define OP1_RESET        8'h01
`define OP2_RESET        8'h00
`define INT_MASK_RESET   3'h0

`define OP1_SWRES        7
`define OP1_LBD_EN       6
`define OP1_WUT_EN       5
`define OP1_SLOW_SEL     4
`define OP1_TX_ON        3
`define OP1_RX_ON        2
`define OP1_SYNTH_ON     1
`define OP1_XTAL_ON      0

`define OP2_ANTDIV_HI    7
`define OP2_ANTDIV_LO    5
`define OP2_MULTI_PKT    4
`define OP2_AUTO_TX      3
`define OP2_LOW_DUTY     2
`define OP2_RX_FIFO_CLR  1
`define OP2_TX_FIFO_CLR  0

`define ST_WUT           0
`define ST_LBD           1
`define ST_RDY           2
`define ST_WIDTH         3
`define ST_RDY_LEVEL     7

`define CLK_MHZ          50
`define XTAL_SETTLE_US   10
`define XTAL_SETTLE_CYC  (`XTAL_SETTLE_US * `CLK_MHZ)
`define WUT_PERIOD_US    1000
`define WUT_PERIOD_CYC   (`WUT_PERIOD_US * `CLK_MHZ)

`endif

// ===== wake_timer.v
// Purpose: Free-running wake-up timer with a one-cycle expiry pulse.
// Assumes: Enable comes from logic on the same clock.
// Notes:   Dropping the enable restarts the count from zero.
`timescale 1ns/1ps
module wake_timer #(
  parameter [31:0] PERIOD_CYC = 32'h0000C350
)(
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        enable,
  output reg         expire_r
);

  reg  [31:0] cnt_r;
  wire        at_end;

  assign at_end = (cnt_r == (PERIOD_CYC - 32'h00000001));

  always @(posedge sys_clk)
  begin
    if (srst || !enable)
    begin
      cnt_r    <= 32'h00000000;
      expire_r <= 1'b0;
    end
    else if (at_end)
    begin
      cnt_r    <= 32'h00000000;
      expire_r <= 1'b1;
    end
    else
    begin
      cnt_r    <= cnt_r + 32'h00000001;
      expire_r <= 1'b0;
    end
  end

endmodule

// ===== settle_timer.v
// Purpose: Crystal settling delay that raises a ready level.
// Assumes: Request is a level from logic on the same clock.
// Notes:   Ready holds until the request falls, which marks idle.
`timescale 1ns/1ps
module settle_timer #(
  parameter [31:0] SETTLE_CYC = 32'h000001F4
)(
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        request,
  output reg         ready_r
);

  reg  [31:0] cnt_r;

  always @(posedge sys_clk)
  begin
    if (srst || !request)
    begin
      cnt_r   <= 32'h00000000;
      ready_r <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (cnt_r == (SETTLE_CYC - 32'h00000001))
        ready_r <= 1'b1;
      else
        cnt_r <= cnt_r + 32'h00000001;
    end
  end

endmodule

// ===== mode_ctrl_properties.sv
// Purpose: Port-level checks of the operating-mode register bank.
// Assumes: Control 1 sits at byte 0x1C and control 2 at byte 0x20.
// Notes:   Self-clear checks skip cycles that carry a control-1 write.
`timescale 1ns/1ps
module mode_ctrl_properties (
  input wire        sys_clk,
  input wire        srst,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        pkt_sent,
  input wire        pkt_valid,
  input wire        fifo_mode,
  input wire        lbd_enable,
  input wire        wut_enable,
  input wire        slow_clock_source_select,
  input wire        tx_enable,
  input wire        rx_enable,
  input wire        synth_idle_on,
  input wire        xtal_on,
  input wire [2:0]  antenna_div,
  input wire        multi_pkt_rx,
  input wire        auto_tx,
  input wire        low_duty_en,
  input wire        rx_fifo_clear,
  input wire        tx_fifo_clear,
  input wire        chip_ready
);
  wire [6:0] op1 = {lbd_enable, wut_enable, slow_clock_source_select,
                    tx_enable, rx_enable, synth_idle_on, xtal_on};
  wire [7:0] op2 = {antenna_div, multi_pkt_rx, auto_tx, low_duty_en,
                    rx_fifo_clear, tx_fifo_clear};
  wire       tk  = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire       wr1 = tk && avs_address[7:2] == 6'h07;
  wire       wr2 = tk && avs_address[7:2] == 6'h08;
  wire       req = xtal_on || tx_enable || rx_enable;
  reg  [9:0] cnt_r;

  // The count saturates so a long ready period cannot wrap it.
  always @(posedge sys_clk)
  begin
    if (srst || !req)
      cnt_r <= 10'h000;
    else if (cnt_r != 10'h3FF)
      cnt_r <= cnt_r + 10'h001;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence soft_s;
    wr1 ##0 avs_writedata[7];
  endsequence
  sequence tx_done_s;
    fifo_mode && pkt_sent && !wr1;
  endsequence
  sequence rx_done_s;
    pkt_valid && !multi_pkt_rx && !wr1;
  endsequence

  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("access waited more than one cycle");
  soft_reset_a: assert property (soft_s |=> op1 == 7'h01 &&
    op2 == 8'h00) else $error("soft reset left a register changed");
  op1_store_a: assert property (wr1 && !avs_writedata[7]
    |=> op1 == $past(avs_writedata[6:0])) else $error("control 1 lost");
  op2_store_a: assert property (wr2
    |=> op2 == $past(avs_writedata[7:0])) else $error("control 2 lost");
  lane_ignore_a: assert property (avs_write && !avs_waitrequest
    && !avs_byteenable[0] && !pkt_sent && !pkt_valid
    |=> $stable(op1) && $stable(op2)) else $error("masked write stored");
  tx_clear_a: assert property (tx_done_s |=> !tx_enable)
    else $error("transmit bit not cleared");
  rx_clear_a: assert property (rx_done_s |=> !rx_enable)
    else $error("receive bit not cleared");
  ready_idle_a: assert property (!req |=> !chip_ready)
    else $error("chip ready held in idle");
  ready_settle_a: assert property ($rose(chip_ready)
    |-> cnt_r >= 10'h1F2 && cnt_r <= 10'h1F6) else $error("settle count off");
endmodule

bind mode_ctrl mode_ctrl_properties chk_i (.sys_clk, .srst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .pkt_sent, .pkt_valid, .fifo_mode, .lbd_enable, .wut_enable,
  .slow_clock_source_select, .tx_enable, .rx_enable, .synth_idle_on,
  .xtal_on, .antenna_div, .multi_pkt_rx, .auto_tx, .low_duty_en,
  .rx_fifo_clear, .tx_fifo_clear, .chip_ready);

// ===== radio_core_model.sv
// Purpose: Stand-in for the radio core that reports packet events.
// Assumes: Events are one-cycle pulses on the system clock.
// Notes:   The battery pin is moved on an edge only to keep runs repeatable.
`timescale 1ns/1ps
module radio_core_model (
  input  wire sys_clk,
  output reg  pkt_sent,
  output reg  pkt_valid,
  output reg  fifo_mode,
  output reg  batt_low_pin
);
  initial
  begin
    pkt_sent = 1'b0;
    pkt_valid = 1'b0;
    fifo_mode = 1'b0;
    batt_low_pin = 1'b0;
  end

  task sent(input m, input integer gap);
  begin
    @(posedge sys_clk);
    fifo_mode <= m;
    repeat (gap) @(posedge sys_clk);
    pkt_sent <= 1'b1;
    @(posedge sys_clk);
    pkt_sent <= 1'b0;
  end
  endtask

  task got(input integer gap);
  begin
    repeat (gap + 1) @(posedge sys_clk);
    pkt_valid <= 1'b1;
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
  end
  endtask

  task batt(input v);
  begin
    @(posedge sys_clk);
    batt_low_pin <= v;
  end
  endtask
endmodule

// ===== tb_radio_operating_mode_control.sv
// Purpose: Register-level test of the operating-mode register bank.
// Assumes: A short wake period keeps the run brief.
// Notes:   Outputs are sampled on the falling edge, after updates land.
`timescale 1ns/1ps
module tb_radio_operating_mode_control;
  reg         sys_clk = 1'b0;
  reg         srst = 1'b1;
  reg  [7:0]  avs_address = 8'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h00000000;
  reg  [3:0]  avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, pkt_sent, pkt_valid, fifo_mode, batt_low_pin;
  wire [6:0]  op1;
  wire [7:0]  op2;
  wire        chip_ready, irq_r, gpio_irq_n_r;
  integer     n_errors = 0;
  integer     n_tests = 0;
  integer     i;

  always #10 sys_clk = ~sys_clk;

  radio_core_model radio_core_model_i (.sys_clk(sys_clk),
    .pkt_sent(pkt_sent), .pkt_valid(pkt_valid), .fifo_mode(fifo_mode),
    .batt_low_pin(batt_low_pin));

  mode_ctrl #(.WUT_CYC(32'h00000014)) mode_ctrl_i (.sys_clk(sys_clk),
    .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .batt_low_pin(batt_low_pin),
    .pkt_sent(pkt_sent), .pkt_valid(pkt_valid), .fifo_mode(fifo_mode),
    .lbd_enable(op1[6]), .wut_enable(op1[5]),
    .slow_clock_source_select(op1[4]), .tx_enable(op1[3]),
    .rx_enable(op1[2]), .synth_idle_on(op1[1]), .xtal_on(op1[0]),
    .antenna_div(op2[7:5]), .multi_pkt_rx(op2[4]), .auto_tx(op2[3]),
    .low_duty_en(op2[2]), .rx_fifo_clear(op2[1]), .tx_fifo_clear(op2[0]),
    .chip_ready(chip_ready), .irq_r(irq_r), .gpio_irq_n_r(gpio_irq_n_r));

  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [7:0] a, input [7:0] v, input [3:0] be);
  begin
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, v};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest)
      @(posedge sys_clk);
    avs_write <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, input [31:0] m, input [31:0] exp);
  begin
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge sys_clk);
    while (avs_waitrequest)
      @(posedge sys_clk);
    chk(avs_readdata & m, exp);
    avs_read <= 1'b0;
  end
  endtask

  task settle(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask

  task test_done;
  begin
    $display("Checks run %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h1C, 32'hFFFFFFFF, 32'h00000001);
    rd(8'h20, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h44, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h60, 8'hFF, 4'hF);
    rd(8'h60, 32'hFFFFFFFF, 32'h00000000);
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(8'h1C, 8'h01 << i, 4'hF);
      settle(1);
      chk(op1, 32'h00000001 << i);
      rd(8'h1C, 32'h000000FF, 32'h00000001 << i);
    end
    wr(8'h20, 8'hFF, 4'hF);
    settle(1);
    chk(op2, 32'h000000FF);
    wr(8'h20, 8'h5A, 4'hE);
    rd(8'h20, 32'h000000FF, 32'h000000FF);
    wr(8'h1C, 8'hC0, 4'hF);
    rd(8'h1C, 32'h000000FF, 32'h00000001);
    rd(8'h20, 32'h000000FF, 32'h00000000);
    settle(505);
    chk(chip_ready, 32'h00000001);
    rd(8'h40, 32'h00000084, 32'h00000084);
    wr(8'h1C, 8'h00, 4'hF);
    settle(3);
    chk(chip_ready, 32'h00000000);
    wr(8'h1C, 8'h08, 4'hF);
    radio_core_model_i.sent(1'b0, 2);
    settle(2);
    chk(op1, 32'h00000008);
    radio_core_model_i.sent(1'b1, 0);
    settle(2);
    chk(op1, 32'h00000000);
    wr(8'h20, 8'h10, 4'hF);
    wr(8'h1C, 8'h04, 4'hF);
    radio_core_model_i.got(5);
    settle(2);
    chk(op1, 32'h00000004);
    wr(8'h20, 8'h00, 4'hF);
    radio_core_model_i.got(0);
    settle(2);
    chk(op1, 32'h00000000);
    wr(8'h1C, 8'h08, 4'hF);
    wr(8'h1C, 8'h00, 4'hF);
    settle(1);
    chk(op1, 32'h00000000);
    wr(8'h40, 8'h07, 4'hF);
    wr(8'h44, 8'h01, 4'hF);
    wr(8'h1C, 8'h20, 4'hF);
    settle(30);
    chk({irq_r, gpio_irq_n_r}, 32'h00000002);
    rd(8'h40, 32'h00000001, 32'h00000001);
    wr(8'h44, 8'h00, 4'hF);
    settle(3);
    chk(irq_r, 32'h00000000);
    wr(8'h1C, 8'h40, 4'hF);
    wr(8'h40, 8'h03, 4'hF);
    rd(8'h40, 32'h00000003, 32'h00000000);
    radio_core_model_i.batt(1'b1);
    settle(6);
    rd(8'h40, 32'h00000002, 32'h00000002);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    settle(1);
    chk({irq_r, gpio_irq_n_r}, 32'h00000001);
    rd(8'h1C, 32'hFFFFFFFF, 32'h00000001);
    rd(8'h40, 32'h00000007, 32'h00000000);
    rd(8'h44, 32'hFFFFFFFF, 32'h00000000);
    test_done;
  end

  // The full sequence needs about 720 cycles; this allows ample margin.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule
